// [core/cfi_pkg.sv]
package cfi_pkg;
    localparam int ADDR_W = 48;
    localparam int DATA_W = 32;
    localparam logic [47:0] CSR_UPPER = 48'hFFFF_F0F0_0000;
    localparam logic [11:0] OFS_GAIN_CAP = 12'h520;
    localparam logic [11:0] OFS_TRIG_CAP = 12'h530;
    localparam logic [11:0] OFS_RATE_CAP = 12'h53C;
    localparam logic [11:0] OFS_RATE_SEL = 12'h600;
    localparam logic [11:0] OFS_MODE_SEL = 12'h604;
    // Bit 0 is the word's most significant bit; this maps it to a vector index.
    localparam int FLD_EXISTS = 31 - 0;
    localparam int FLD_ABS = 31 - 1;
    localparam int FLD_ONE_PUSH = 31 - 3;
    localparam int FLD_READABLE = 31 - 4;
    localparam int FLD_ON_OFF = 31 - 5;
    localparam int FLD_AUTO = 31 - 6;
    localparam int FLD_MANUAL = 31 - 7;
    localparam int FLD_POLARITY = 31 - 6;
    localparam int FLD_RAW_READ = 31 - 7;
    localparam int FLD_MIN_HI = 31 - 8;
    localparam int FLD_MAX_HI = 31 - 20;
    localparam int FLD_HWSRC_HI = 31 - 8;
    localparam int FLD_SWSRC = 31 - 15;
    localparam int FLD_TMODE_HI = 31 - 16;
    localparam int FLD_VMODE14 = 31 - 30;
    localparam int FLD_VMODE15 = 31 - 31;
    localparam int FLD_SEL_HI = 31 - 0;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] FMT_STILL = 3'h6;
    localparam logic [2:0] FMT_SCALABLE = 3'h7;

    typedef struct packed {
        logic exists;
        logic absolute;
        logic one_push;
        logic readable;
        logic on_off;
        logic auto_mode;
        logic manual;
        logic [11:0] min_val;
        logic [11:0] max_val;
    } cfi_feat_t;

    typedef struct packed {
        logic exists;
        logic absolute;
        logic readable;
        logic on_off;
        logic polarity;
        logic raw_read;
        logic [3:0] hw_src;
        logic sw_src;
        logic [5:0] modes;
        logic [1:0] vendor_modes;
    } cfi_trig_t;

    typedef struct packed {
        logic rate_valid;
        logic rev_valid;
        logic [2:0] rate;
        logic [2:0] revision;
    } cfi_rate_t;
endpackage

// [core/cfi_pack.sv]
`timescale 1ns/100ps
module cfi_pack
    import cfi_pkg::*;
(
    input wire cfi_feat_t feat,
    output logic [31:0] word
);
    always_comb begin
        word = '0;
        word[FLD_EXISTS] = feat.exists;
        word[FLD_ABS] = feat.absolute;
        word[FLD_ONE_PUSH] = feat.one_push;
        word[FLD_READABLE] = feat.readable;
        word[FLD_ON_OFF] = feat.on_off;
        word[FLD_AUTO] = feat.auto_mode;
        word[FLD_MANUAL] = feat.manual;
        word[FLD_MIN_HI -: 12] = feat.min_val;
        word[FLD_MAX_HI -: 12] = feat.max_val;
    end
endmodule

// [core/cfi_csr.sv]
`timescale 1ns/100ps
module cfi_csr
    import cfi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [9:0] bus_id,
    input wire logic [5:0] node_id,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W+15:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic resp_valid,
    output logic resp_hit,
    output logic [DATA_W-1:0] resp_rdata,
    input wire logic [2:0] video_format,
    input wire cfi_feat_t gain_caps,
    input wire cfi_trig_t trig_caps,
    input wire cfi_feat_t rate_caps,
    output cfi_rate_t rate_sel,
    output logic [2:0] video_mode,
    output logic mode_changed
);
    logic [2:0] sel_q;
    logic [2:0] sel_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic resp_valid_q;
    logic resp_hit_q;
    logic [31:0] rdata_q;
    logic mode_chg_q;
    logic [2:0] fmt_q;
    logic [31:0] gain_word;
    logic [31:0] rate_word;
    logic [31:0] trig_word;
    logic [31:0] read_mux;

    // full node address is base plus offset.
    wire [63:0] base_addr = {bus_id, node_id, CSR_UPPER};
    wire [63:0] offs = req_addr - base_addr;
    wire in_space = (offs[63:12] == '0);
    wire [11:0] ofs = offs[11:0];
    wire hit_gain = in_space && ofs == OFS_GAIN_CAP;
    wire hit_trig = in_space && ofs == OFS_TRIG_CAP;
    wire hit_rcap = in_space && ofs == OFS_RATE_CAP;
    wire hit_rsel = in_space && ofs == OFS_RATE_SEL;
    wire hit_mode = in_space && ofs == OFS_MODE_SEL;
    wire hit_any = hit_gain | hit_trig | hit_rcap | hit_rsel | hit_mode;
    wire wr = req_valid && req_write;

    // gain flags and limits from live inputs.
    cfi_pack u_gain (
        .feat(gain_caps),
        .word(gain_word)
    );
    // frame-rate word shares the gain layout.
    cfi_pack u_rate (
        .feat(rate_caps),
        .word(rate_word)
    );

    always_comb begin
        trig_word = '0;
        trig_word[FLD_EXISTS] = trig_caps.exists;
        trig_word[FLD_ABS] = trig_caps.absolute;
        trig_word[FLD_READABLE] = trig_caps.readable;
        trig_word[FLD_ON_OFF] = trig_caps.on_off;
        trig_word[FLD_POLARITY] = trig_caps.polarity;
        trig_word[FLD_RAW_READ] = trig_caps.raw_read;
        trig_word[FLD_HWSRC_HI -: 4] = trig_caps.hw_src;
        trig_word[FLD_SWSRC] = trig_caps.sw_src;
        trig_word[FLD_TMODE_HI -: 6] = trig_caps.modes;
        trig_word[FLD_VMODE14] = trig_caps.vendor_modes[1];
        trig_word[FLD_VMODE15] = trig_caps.vendor_modes[0];
    end

    // reserved bits read zero, unmapped reads zero.
    assign read_mux = hit_gain ? gain_word :
                      hit_trig ? trig_word :
                      hit_rcap ? rate_word :
                      hit_rsel ? {sel_q, 29'h0} :
                      hit_mode ? {mode_q, 29'h0} : 32'h0;

    // mode field is the top three bits.
    assign mode_d = (wr && hit_mode) ? req_wdata[FLD_SEL_HI -: 3] : mode_q;
    // capability writes fall through without effect.
    assign sel_d = (wr && hit_rsel) ? req_wdata[FLD_SEL_HI -: 3] : sel_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_q <= SEL_RESET;
            mode_q <= SEL_RESET;
            fmt_q <= SEL_RESET;
            mode_chg_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_hit_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            sel_q <= sel_d;
            mode_q <= mode_d;
            fmt_q <= video_format;
            // flag a format or mode change so host rereads.
            mode_chg_q <= (mode_d != mode_q) || (video_format != fmt_q);
            resp_valid_q <= req_valid;
            resp_hit_q <= req_valid && hit_any;
            rdata_q <= (req_valid && !req_write) ? read_mux : 32'h0;
        end
    end

    // formats 0 to 2 take the field as a rate.
    assign rate_sel.rate_valid = video_format <= 3'h2;
    assign rate_sel.rate = (video_format <= 3'h2) ? sel_q : 3'h0;
    // format 6 takes the field as a revision.
    assign rate_sel.rev_valid = video_format == FMT_STILL;
    assign rate_sel.revision = (video_format == FMT_STILL) ? sel_q : 3'h0;
    // format 7 sees neither rate nor revision.
    assign video_mode = mode_q;
    assign mode_changed = mode_chg_q;
    assign resp_valid = resp_valid_q;
    assign resp_hit = resp_hit_q;
    assign resp_rdata = rdata_q;
endmodule

// [verification/cfi_csr_chk.sv]
`timescale 1ns/100ps
module cfi_chk
    import cfi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic resp_valid,
    input wire logic resp_hit,
    input wire logic [DATA_W-1:0] resp_rdata,
    input wire logic [2:0] video_format,
    input wire cfi_rate_t rate_sel,
    input wire logic [2:0] video_mode,
    input wire logic mode_changed
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_resp_next: assert property (req_valid |=> resp_valid)
        else $error("No answer.");
    a_resp_idle: assert property (!req_valid |=> !resp_valid)
        else $error("Stray answer.");
    a_miss_zero: assert property (resp_valid && !resp_hit |-> !resp_rdata)
        else $error("Miss data.");
    a_rate_sel: assert property (video_format < 3'h3 |-> rate_sel.rate_valid)
        else $error("Rate off.");
    a_rev_sel: assert property (video_format == FMT_STILL |-> rate_sel.rev_valid)
        else $error("Rev off.");
    a_fmt_ignore: assert property (video_format == FMT_SCALABLE
        |-> !rate_sel.rate_valid && !rate_sel.rev_valid) else $error("Used.");
    a_mode_hold: assert property (!req_valid |=> $stable(video_mode))
        else $error("Mode moved.");
    a_fmt_change: assert property ($changed(video_format) |=> mode_changed)
        else $error("No change.");
endmodule
bind cfi_csr cfi_chk chk_u(.sys_clk, .rst, .req_valid, .resp_valid, .resp_hit,
    .resp_rdata, .video_format, .rate_sel, .video_mode, .mode_changed);

// [verification/cfi_host.sv]
`timescale 1ns/100ps
module cfi_host
    import cfi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [9:0] bus_id,
    input wire logic [5:0] node_id,
    output logic req_valid,
    output logic req_write,
    output logic [ADDR_W+15:0] req_addr,
    output logic [DATA_W-1:0] req_wdata
);
    initial req_valid = 1'b0;
    task automatic xfer(input logic w, input logic [11:0] o, input logic [31:0] d);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = {bus_id, node_id, CSR_UPPER} + 64'(o);
        req_wdata = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        // Released address and data lines flip so a stale value is never mistaken for live.
        req_addr = ~req_addr;
        req_wdata = ~d;
    endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
    import cfi_pkg::*;
    logic sys_clk, rst, req_valid, req_write, resp_valid, resp_hit, hit;
    logic mode_changed, mc;
    logic [9:0] bus_id;
    logic [5:0] node_id;
    logic [63:0] req_addr;
    logic [31:0] req_wdata, resp_rdata, s, w, d;
    logic [31:0] ex [6];
    logic [2:0] video_format, video_mode, rs, ms;
    cfi_feat_t gain_caps, rate_caps;
    cfi_trig_t trig_caps;
    cfi_rate_t rate_sel;
    int bad_count, num_checks, k;
    logic [11:0] ofs [6] = '{12'h520, 12'h530, 12'h53C, 12'h600, 12'h604, 12'h608};
    cfi_csr dut_u(.sys_clk, .rst, .bus_id, .node_id, .req_valid, .req_write,
        .req_addr, .req_wdata, .resp_valid, .resp_hit, .resp_rdata,
        .video_format, .gain_caps, .trig_caps, .rate_caps, .rate_sel,
        .video_mode, .mode_changed);
    cfi_host host_u(.sys_clk, .bus_id, .node_id, .req_valid, .req_write,
        .req_addr, .req_wdata);
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        s = 32'h16BE;
        rst = 1'b1;
        {bus_id, node_id} = 16'(xs());
        {video_format, rs, ms} = '0;
        {gain_caps, rate_caps, trig_caps} = '0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 300; i++) begin
            gain_caps = 31'(xs());
            rate_caps = 31'(xs());
            trig_caps = 19'(xs());
            w = xs();
            d = xs();
            video_format = w[2:0];
            k = int'(w[7:4]) % 6;
            ex[0] = {gain_caps[30:29], 1'b0, gain_caps[28:0]};
            ex[2] = {rate_caps[30:29], 1'b0, rate_caps[28:0]};
            ex[1] = {trig_caps[18:17], 2'h0, trig_caps[16:9], 3'h0,
                trig_caps[8:2], 8'h0, trig_caps[1:0]};
            ex[3] = {rs, 29'h0};
            ex[4] = {ms, 29'h0};
            ex[5] = 32'h0;
            hit = k < 5;
            host_u.xfer(w[8], ofs[k], d);
            // The answer stands only until the next rising edge.
            mc = w[8] && k == 4 && d[31:29] != ms;
            if (w[8] && k == 3) rs = d[31:29];
            if (w[8] && k == 4) ms = d[31:29];
            chk({resp_valid, hit, w[8] ? 32'h0 : ex[k]}, {1'b1, resp_hit, resp_rdata});
            chk({rate_sel.rate_valid, rate_sel.rev_valid, rate_sel.rate,
                rate_sel.revision}, {video_format < 3, video_format == 6,
                video_format < 3 ? rs : 3'h0,
                video_format == 6 ? rs : 3'h0});
            chk(34'(video_mode), 34'(ms));
            chk(34'(mode_changed), 34'(mc));
            @(negedge sys_clk);
        end
        end_sim();
    end
endmodule
